//--- core/aesf_pkg.sv
// Constants for the start-up project selection and fail-safe block.
// Assumes one 125 MHz clock and a synchronous active-high reset.
// ==========================================================================
// How it works
// - Whenever the fail-safe clear input opens, running programs and motion stop.
// - Auto-execution after power-up or a reset command starts only if the clear input is active then.
// - The select inputs form a 3-bit index weighted 4, 2, 1 and codes 0 to 6 pick that project.
// - Code seven, all selects active, picks project zero like code zero.
// - After an erase-directory command, loaded projects are numbered 0 upward to at most 6.
package aesf_pkg;
   localparam int AESF_IDX_W = 3;
   localparam logic [2:0] AESF_PROJ_MAX = 3'h6;
   localparam logic [2:0] AESF_CODE_ALIAS = 3'h7;
   localparam logic [2:0] AESF_PROJ_DEFAULT = 3'h0;
   localparam logic [2:0] AESF_SLOT_RESET = 3'h0;
   localparam int AESF_SYNC_STAGES = 2;
   typedef enum logic [1:0] {
      AESF_ST_IDLE = 2'b00,
      AESF_ST_DECIDE = 2'b01,
      AESF_ST_RUN = 2'b10,
      AESF_ST_HALT = 2'b11
   } aesf_state_t;
endpackage

//--- core/aesf_sync.sv
// Two flip-flop synchroniser bank for the isolated discrete inputs.
// Assumes the inputs are asynchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module aesf_sync #(
   parameter int WIDTH = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   if (WIDTH < 1) begin : g_width_chk
      $error("Synchroniser width must be at least one.");
   end
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= din;
         stage2_reg <= stage1_reg;
      end
   end
   assign dout = stage2_reg;
endmodule // aesf_sync
`default_nettype wire

//--- core/aesf_top.sv
// Start-up project selection and fail-safe halt logic.
// Assumes field inputs arrive asynchronously and are active high after the
// isolators; start and command pulses come from logic on mclk.
`timescale 1ns/1ns
`default_nettype none
module aesf_top
   import aesf_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic failsafe_clear_input,
   input wire logic sel4_in,
   input wire logic sel2_in,
   input wire logic sel1_in,
   input wire logic reset_cmd,
   input wire logic erase_dir_cmd,
   input wire logic project_load,
   output logic run_enable,
   output logic motion_enable,
   output logic halt_event,
   output logic autoexec_start,
   output logic [2:0] autoexec_project,
   output logic autoexec_blocked,
   output logic [2:0] load_slot,
   output logic load_accept,
   output logic dir_full,
   output logic [2:0] project_count
);
   if (AESF_IDX_W != 3) begin : g_idx_chk
      $error("Index width must be three.");
   end

   // ======================================================================
   // Input synchronisers
   logic [3:0] sync_out;
   aesf_sync #(.WIDTH(4)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .din({failsafe_clear_input, sel4_in, sel2_in, sel1_in}),
      .dout(sync_out)
   );
   wire clr_ok = sync_out[3];
   wire [2:0] sel_code = sync_out[2:0];

   function automatic logic [2:0] map_code(input logic [2:0] c);
      map_code = (c == AESF_CODE_ALIAS) ? AESF_PROJ_DEFAULT : c;
   endfunction

   // ======================================================================
   // Start decision and run control
   aesf_state_t state_reg, state_next;
   logic [2:0] proj_reg;
   logic start_reg, blocked_reg, halt_reg, clr_d_reg;
   logic [1:0] boot_cnt_reg;
   wire boot_done = (boot_cnt_reg == 2'h3);
   // The first decision waits until the synchroniser holds real samples.
   wire decide = (state_reg == AESF_ST_IDLE && boot_done) || reset_cmd;
   wire go = decide && clr_ok;
   wire clr_fall = clr_d_reg && !clr_ok;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         AESF_ST_IDLE: if (boot_done) state_next = AESF_ST_DECIDE;
         AESF_ST_DECIDE: state_next = AESF_ST_DECIDE;
         AESF_ST_RUN: if (!clr_ok) state_next = AESF_ST_HALT;
         AESF_ST_HALT: state_next = AESF_ST_HALT;
      endcase
      if (decide) state_next = go ? AESF_ST_RUN : AESF_ST_DECIDE;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= AESF_ST_IDLE;
         proj_reg <= AESF_PROJ_DEFAULT;
         start_reg <= 1'b0;
         blocked_reg <= 1'b0;
         halt_reg <= 1'b0;
         clr_d_reg <= 1'b0;
         boot_cnt_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         clr_d_reg <= clr_ok;
         if (!boot_done) boot_cnt_reg <= boot_cnt_reg + 2'h1;
         if (decide) proj_reg <= map_code(sel_code);
         start_reg <= go;
         blocked_reg <= decide ? !clr_ok : blocked_reg;
         halt_reg <= clr_fall && state_reg == AESF_ST_RUN;
      end
   end

   assign run_enable = (state_reg == AESF_ST_RUN) && clr_ok;
   assign motion_enable = run_enable;
   assign halt_event = halt_reg;
   assign autoexec_start = start_reg;
   assign autoexec_project = proj_reg;
   assign autoexec_blocked = blocked_reg;

   // ======================================================================
   // Directory slot numbering
   logic [2:0] slot_reg;
   logic full_reg, accept_reg;
   wire can_load = project_load && !full_reg && !erase_dir_cmd;

   always_ff @(posedge mclk) begin
      if (rst) begin
         slot_reg <= AESF_SLOT_RESET;
         full_reg <= 1'b0;
         accept_reg <= 1'b0;
      end else begin
         accept_reg <= can_load;
         if (erase_dir_cmd) begin
            slot_reg <= AESF_SLOT_RESET;
            full_reg <= 1'b0;
         end else if (can_load) begin
            if (slot_reg == AESF_PROJ_MAX) full_reg <= 1'b1;
            else slot_reg <= slot_reg + 3'h1;
         end
      end
   end

   assign load_slot = slot_reg;
   assign load_accept = accept_reg;
   assign dir_full = full_reg;
   assign project_count = full_reg ? AESF_CODE_ALIAS : slot_reg;

   // ======================================================================
   // Checks
   // Fail-safe halt.
   AST_HALT_ON_OPEN: assert property (
      @(posedge mclk) disable iff (rst)
      !clr_ok |-> !run_enable && !motion_enable)
      else $error("Motion enabled with clear input open.");
   AST_HALT_PULSE: assert property (
      @(posedge mclk) disable iff (rst)
      (state_reg == AESF_ST_RUN && clr_fall) |=> halt_event)
      else $error("No halt pulse on clear opening.");
   AST_HALT_ONE_CYCLE: assert property (
      @(posedge mclk) disable iff (rst)
      halt_event |=> !halt_event)
      else $error("Halt pulse longer than one cycle.");
   AST_HALT_STATE: assert property (
      @(posedge mclk) disable iff (rst)
      halt_event |-> state_reg == AESF_ST_HALT)
      else $error("Halt pulse without entering the halted state.");
   AST_STAY_HALTED: assert property (
      @(posedge mclk) disable iff (rst)
      (state_reg == AESF_ST_HALT && !reset_cmd) |=> !run_enable)
      else $error("Run resumed without a new decision.");
   // Start decision.
   AST_START_NEEDS_CLR: assert property (
      @(posedge mclk) disable iff (rst)
      autoexec_start |-> $past(clr_ok))
      else $error("Auto-execute started without clear input.");
   AST_START_ON_DECIDE: assert property (
      @(posedge mclk) disable iff (rst)
      (decide && clr_ok) |=> autoexec_start && state_reg == AESF_ST_RUN)
      else $error("Auto-execute missed a valid decision.");
   AST_BLOCK_ON_OPEN: assert property (
      @(posedge mclk) disable iff (rst)
      (decide && !clr_ok) |=> autoexec_blocked && !autoexec_start)
      else $error("Refused decision not flagged.");
   AST_NO_START_IDLE: assert property (
      @(posedge mclk) disable iff (rst)
      !decide |=> !autoexec_start)
      else $error("Start pulse without a decision.");
   AST_RUN_NEEDS_START: assert property (
      @(posedge mclk) disable iff (rst)
      $rose(state_reg == AESF_ST_RUN) |-> autoexec_start)
      else $error("Run entered without a start pulse.");
   AST_INDEX: assert property (
      @(posedge mclk) disable iff (rst)
      (decide && sel_code != 3'h7) |=> autoexec_project == $past(sel_code))
      else $error("Project index does not match selects.");
   AST_PROJ_RANGE: assert property (
      @(posedge mclk) disable iff (rst)
      autoexec_project <= AESF_PROJ_MAX)
      else $error("Project index beyond six.");
   AST_CODE7: assert property (
      @(posedge mclk) disable iff (rst)
      (decide && sel_code == 3'h7) |=> autoexec_project == 3'h0)
      else $error("Code seven did not pick project zero.");
   AST_HOLD: assert property (
      @(posedge mclk) disable iff (rst)
      !decide |=> $stable(autoexec_project))
      else $error("Project index changed without a decision.");
   // Directory numbering.
   AST_SLOT_LIMIT: assert property (
      @(posedge mclk) disable iff (rst)
      load_slot <= 3'h6)
      else $error("Load slot beyond six.");
   AST_ERASE: assert property (
      @(posedge mclk) disable iff (rst)
      erase_dir_cmd |=> load_slot == 3'h0 && !dir_full)
      else $error("Erase did not restart numbering.");
   AST_ACCEPT: assert property (
      @(posedge mclk) disable iff (rst)
      can_load |=> load_accept)
      else $error("Valid load not accepted.");
   AST_NO_ACCEPT_FULL: assert property (
      @(posedge mclk) disable iff (rst)
      dir_full |=> !load_accept)
      else $error("Load accepted with the directory full.");
   AST_SLOT_STEP: assert property (
      @(posedge mclk) disable iff (rst)
      (can_load && slot_reg != AESF_PROJ_MAX) |=>
         load_slot == $past(load_slot) + 3'h1)
      else $error("Load slot did not advance by one.");
   AST_FULL_COUNT: assert property (
      @(posedge mclk) disable iff (rst)
      dir_full |-> project_count == AESF_CODE_ALIAS)
      else $error("Full directory does not count seven projects.");
   COV_START: cover property (@(posedge mclk) disable iff (rst)
      autoexec_start);
   COV_CODE7: cover property (@(posedge mclk) disable iff (rst)
      decide && sel_code == AESF_CODE_ALIAS);
   COV_BLOCKED: cover property (@(posedge mclk) disable iff (rst)
      decide && !clr_ok);
   COV_HALT: cover property (@(posedge mclk) disable iff (rst) halt_event);
   COV_FULL: cover property (@(posedge mclk) disable iff (rst)
      $rose(dir_full));
endmodule // aesf_top
`default_nettype wire

//--- testbench/aesf_field_model.sv
// Field side model: fail-safe loop contact and project select switches.
// Assumes the bench sets the wanted contact positions between clock edges.
`timescale 1ns/1ns
`default_nettype none
module aesf_field_model (
   input wire logic closed,
   input wire logic [2:0] code,
   output logic failsafe_clear_input,
   output logic sel4_in,
   output logic sel2_in,
   output logic sel1_in
);
   // ==========================================================
   // Contacts
   // A closed loop or an on switch reads high after the isolator.
   assign failsafe_clear_input = closed;
   assign {sel4_in, sel2_in, sel1_in} = code;
endmodule // aesf_field_model
`default_nettype wire

//--- testbench/tb_top.sv
// Bench for the start-up selection and fail-safe block.
// Assumes a 125 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import aesf_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, closed = 1'b1, reset_cmd = 1'b0;
   logic erase_dir_cmd = 1'b0, project_load = 1'b0;
   logic [2:0] code = 3'h5;
   logic clr_pin, s4, s2, s1, run_enable, motion_enable, halt_event;
   logic autoexec_start, autoexec_blocked, load_accept, dir_full;
   logic [2:0] autoexec_project, load_slot, project_count;
   int fails = 0, tests_run = 0, i, n;
   initial forever #4 mclk = ~mclk;
   aesf_field_model u_aesf_field_model (.closed(closed), .code(code),
      .failsafe_clear_input(clr_pin), .sel4_in(s4), .sel2_in(s2),
      .sel1_in(s1));
   aesf_top u_aesf_top (.mclk(mclk), .rst(rst),
      .failsafe_clear_input(clr_pin), .sel4_in(s4), .sel2_in(s2),
      .sel1_in(s1), .reset_cmd(reset_cmd), .erase_dir_cmd(erase_dir_cmd),
      .project_load(project_load), .run_enable(run_enable),
      .motion_enable(motion_enable), .halt_event(halt_event),
      .autoexec_start(autoexec_start), .autoexec_project(autoexec_project),
      .autoexec_blocked(autoexec_blocked), .load_slot(load_slot),
      .load_accept(load_accept), .dir_full(dir_full),
      .project_count(project_count));
   // ==========================================================
   // Tasks
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // Waits for a start pulse or for the refused flag, at most 8 cycles.
   task automatic wait_for(input bit want_start);
      n = 0;
      while ((want_start ? autoexec_start : autoexec_blocked) !== 1'b1) begin
         tick(1);
         n++;
         if (n > 8) begin
            check(3'h1, 3'h0);
            complete_run();
         end
      end
   endtask
   task automatic pulse_reset_cmd;
      reset_cmd = 1'b1;
      tick(1);
      reset_cmd = 1'b0;
   endtask
   // ==========================================================
   // Sequence
   initial begin
      tick(10);
      rst = 1'b0;
      wait_for(1);
      check(autoexec_project, 3'h5);
      check({1'b0, run_enable, motion_enable}, 3'h3);
      for (i = 0; i < 8; i++) begin
         code = i[2:0];
         tick(4);
         pulse_reset_cmd();
         wait_for(1);
         check(autoexec_project, (i == 7) ? 3'h0 : i[2:0]);
      end
      code = 3'h2;
      tick(6);
      check(autoexec_project, AESF_PROJ_DEFAULT);
      closed = 1'b0;
      n = 0;
      while (halt_event !== 1'b1 && n < 8) begin
         tick(1);
         n++;
      end
      check({2'b0, halt_event}, 3'h1);
      check({1'b0, run_enable, motion_enable}, 3'h0);
      pulse_reset_cmd();
      wait_for(0);
      check({autoexec_start, autoexec_blocked, run_enable}, 3'h2);
      erase_dir_cmd = 1'b1;
      tick(1);
      erase_dir_cmd = 1'b0;
      tick(1);
      check(load_slot, AESF_SLOT_RESET);
      n = 0;
      project_load = 1'b1;
      for (i = 0; i < 8; i++) begin
         tick(1);
         n += (load_accept === 1'b1);
      end
      project_load = 1'b0;
      tick(1);
      check(n[2:0], 3'h7);
      check({2'b0, dir_full}, 3'h1);
      check(project_count, 3'h7);
      check(load_slot, AESF_PROJ_MAX);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
